/* verilog/wsw_pkg.sv */
// Purpose: Shared constants and types of the watchdog, sleep and wake-up block.
// Assumes: clk_sys runs at 100 MHz; registers are reached over AHB-Lite.
// Notes:   Byte addresses of the option and configuration registers are four times their index.
`default_nettype none
package wsw_pkg;
    // Clock and time figures.
    localparam int unsigned WSW_CLK_PERIOD_NS  = 10;
    localparam int unsigned WSW_WDT_PERIOD_MS  = 18;
    localparam int unsigned WSW_WDT_BASE_CYC   = WSW_WDT_PERIOD_MS * 1000000 / WSW_CLK_PERIOD_NS;
    localparam int unsigned WSW_OSC_PERIOD_NS  = 10;
    localparam int unsigned WSW_OST_TOSC       = 1024;
    localparam int unsigned WSW_OST_CYC        = (WSW_OST_TOSC * WSW_OSC_PERIOD_NS + WSW_CLK_PERIOD_NS - 1)
                                                 / WSW_CLK_PERIOD_NS;
    localparam logic [10:0] WSW_OST_LAST       = 11'(WSW_OST_CYC - 1);

    // Register indices and byte addresses.
    localparam logic [15:0] WSW_OPTION_IDX     = 16'h0081;
    localparam logic [15:0] WSW_CONFIG_IDX     = 16'h2007;
    localparam logic [15:0] WSW_OPTION_ADDR    = 16'(WSW_OPTION_IDX * 4);
    localparam logic [15:0] WSW_CONFIG_ADDR    = 16'(WSW_CONFIG_IDX * 4);
    localparam logic [15:0] WSW_CORE_STS_ADDR  = 16'h0000;
    localparam logic [15:0] WSW_IRQ_STS_ADDR   = 16'h0004;
    localparam logic [15:0] WSW_IRQ_CLR_ADDR   = 16'h0008;
    localparam logic [15:0] WSW_IRQ_EN_ADDR    = 16'h000c;

    // Field positions.
    localparam int unsigned WSW_OPT_PRE_BIT    = 3;
    localparam int unsigned WSW_CFG_WEN_BIT    = 3;
    localparam logic [2:0]  WSW_FOSC_HS        = 3'h2;
    localparam int unsigned WSW_EV_WDT_RESET   = 0;
    localparam int unsigned WSW_EV_WDT_WAKE    = 1;
    localparam int unsigned WSW_EV_IRQ_WAKE    = 2;

    // Values after reset.
    localparam logic [7:0]  WSW_OPTION_RST     = 8'hff;
    localparam logic [2:0]  WSW_IRQ_RST        = 3'h0;

    // Power states, one-hot.
    typedef enum logic [2:0] {
        WSW_RUN   = 3'b001,
        WSW_SLEEP = 3'b010,
        WSW_START = 3'b100
    } wsw_state_e;

    // Last prescaler count for a ratio of one in two to the power of sel.
    function automatic logic [7:0] wsw_ratio_last(input logic [2:0] sel);
        wsw_ratio_last = 8'((9'h001 << sel) - 9'h001);
    endfunction
endpackage : wsw_pkg
`default_nettype wire

/* verilog/wsw_wdt_timer.sv */
// Purpose: Watchdog counter with optional prescaler, paced by a free-running base divider.
// Assumes: The base divider stands for the dedicated RC oscillator and never stops.
// Notes:   expire is a one-cycle pulse; the counter restarts by itself after it.
`default_nettype none
module wsw_wdt_timer #(
    parameter int unsigned BASE_CYCLES = wsw_pkg::WSW_WDT_BASE_CYC
) (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Control.
    input  wire logic       enable,
    input  wire logic       clear,
    input  wire logic       prescale_to_wdt,
    input  wire logic [2:0] ratio_sel,
    // Result.
    output logic            expire
);
    import wsw_pkg::*;

    typedef struct packed {
        logic [31:0] base_cnt;
        logic [7:0]  pre_cnt;
        logic        expire;
    } wsw_wdt_s;

    wsw_wdt_s s_reg;
    wsw_wdt_s s_next;

    // Counts base periods, then prescaler steps, independent of the main oscillator.
    always_comb
    begin
        s_next        = s_reg;
        s_next.expire = 1'b0;
        if (!enable || clear)
        begin
            s_next.base_cnt = 32'h0;
            s_next.pre_cnt  = 8'h0;
        end
        else if (s_reg.base_cnt == 32'(BASE_CYCLES - 1))
        begin
            s_next.base_cnt = 32'h0;
            if (!prescale_to_wdt || s_reg.pre_cnt == wsw_ratio_last(ratio_sel))
            begin
                s_next.pre_cnt = 8'h0;
                s_next.expire  = 1'b1;
            end
            else
            begin
                s_next.pre_cnt = s_reg.pre_cnt + 8'h01;
            end
        end
        else
        begin
            s_next.base_cnt = s_reg.base_cnt + 32'h1;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign expire = s_reg.expire;
endmodule : wsw_wdt_timer
`default_nettype wire

/* verilog/wsw_ost_timer.sv */
// Purpose: Oscillator start-up timer run after a wake event in crystal modes.
// Assumes: start is a one-cycle pulse.
// Notes:   done pulses once, the configured number of cycles after start.
`default_nettype none
module wsw_ost_timer (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control.
    input  wire logic start,
    output logic      done
);
    import wsw_pkg::*;

    typedef struct packed {
        logic        busy;
        logic [10:0] cnt;
        logic        done;
    } wsw_ost_s;

    wsw_ost_s s_reg;
    wsw_ost_s s_next;

    // Counts the start-up wait and flags its end.
    always_comb
    begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (start)
        begin
            s_next.busy = 1'b1;
            s_next.cnt  = 11'h0;
        end
        else if (s_reg.busy)
        begin
            if (s_reg.cnt == WSW_OST_LAST)
            begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
            else
            begin
                s_next.cnt = s_reg.cnt + 11'h001;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign done = s_reg.done;
endmodule : wsw_ost_timer
`default_nettype wire

/* verilog/wsw_top.sv */
// Purpose: Watchdog, power-down control and wake-up sequencing with an AHB-Lite register slave.
// Assumes: Core strobes are one-cycle pulses synchronous to clk_sys; rst is the power-up reset.
// Notes:   The watchdog never drives the master-clear pin; its reset request leaves on device_reset only.
`default_nettype none
// Overview of operation
// - Watchdog paced by its own free oscillator.
// - Expiry while running forces device reset.
// - Expiry while asleep wakes and continues.
// - Enable fuse zero disables watchdog forever.
// - Base time-out about 18 ms.
// - Option register assigns prescaler up to 1:128.
// - Clear and sleep instructions clear watchdog.
// - Expiry clears the time-out flag.
// - Sleep entry clears, flags, stops oscillator, holds pins.
// - Watchdog reset never drives master-clear pin.
// - Wake on master-clear, watchdog or interrupt.
// - Power-down flag set at power-up, cleared by sleep.
// - Sleep execution prefetches the next instruction.
// - Enabled interrupt wakes regardless of global enable.
// - After interrupt wake, next instruction, maybe vector.
// - Pending enabled interrupt makes sleep wake immediately.
// - Any wake-up clears the watchdog.
// - Crystal modes wait 1024 oscillator periods after wake; the code skips this wait on a master-clear wake.
module wsw_top #(
    parameter int unsigned WDT_BASE_CYCLES = wsw_pkg::WSW_WDT_BASE_CYC
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Core instruction decode.
    input  wire logic        clear_watchdog_instruction,
    input  wire logic        sleep_instruction,
    // Interrupt logic.
    input  wire logic [7:0]  irq_flags,
    input  wire logic [7:0]  irq_enables,
    input  wire logic        global_interrupt_enable,
    // Pins and configuration.
    input  wire logic        master_clear_pin_n,
    input  wire logic [7:0]  config_word,
    // Core and reset control.
    output logic             device_reset,
    output logic             timeout_status_flag_n,
    output logic             powerdown_status_flag_n,
    output logic             osc_driver_en,
    output logic             io_hold,
    output logic             core_halt,
    output logic             prefetch_next,
    output logic             resume_exec,
    output logic             vector_after_next,
    // Interrupt to the system.
    output logic             irq
);
    import wsw_pkg::*;

    typedef struct packed {
        wsw_state_e  state;
        logic [7:0]  option;
        logic        to_n;
        logic        pwr_n;
        logic        int_wake;
        logic [2:0]  irq_sts;
        logic [2:0]  irq_en;
        logic        wr_pend;
        logic [15:0] wr_addr;
        logic [31:0] rdata;
        logic        dev_rst;
        logic        resume;
        logic        vector;
        logic        prefetch;
    } wsw_top_s;

    wsw_top_s   s_reg;
    wsw_top_s   s_next;
    logic       wdt_enable;
    logic       wdt_clear;
    logic       wdt_expire;
    logic       ost_start;
    logic       ost_done;
    logic       crystal_mode;
    logic       irq_pending;
    logic       pin_rst;
    logic       addr_phase;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;

    // Configuration decode; the fuse alone enables the watchdog.
    assign wdt_enable   = config_word[WSW_CFG_WEN_BIT];
    assign crystal_mode = config_word[2:0] <= WSW_FOSC_HS;
    assign irq_pending  = |(irq_flags & irq_enables);
    assign pin_rst      = !master_clear_pin_n;
    assign addr_phase   = hsel && htrans[1] && hready;

    // Watchdog counter and prescaler.
    wsw_wdt_timer #(
        .BASE_CYCLES     (WDT_BASE_CYCLES)
    ) u_wdt (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .enable          (wdt_enable),
        .clear           (wdt_clear),
        .prescale_to_wdt (s_reg.option[WSW_OPT_PRE_BIT]),
        .ratio_sel       (s_reg.option[2:0]),
        .expire          (wdt_expire)
    );

    // Oscillator start-up timer.
    wsw_ost_timer u_ost (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .start           (ost_start),
        .done            (ost_done)
    );

    // Power sequencing, status flags, events and the register slave.
    always_comb
    begin
        s_next          = s_reg;
        s_next.dev_rst  = 1'b0;
        s_next.resume   = 1'b0;
        s_next.vector   = 1'b0;
        s_next.prefetch = 1'b0;
        wdt_clear       = 1'b0;
        ost_start       = 1'b0;
        ev_set          = 3'h0;
        ev_clr          = 3'h0;

        case (s_reg.state)
            WSW_RUN:
            begin
                if (clear_watchdog_instruction)
                begin
                    wdt_clear   = 1'b1;
                    s_next.to_n = 1'b1;
                    s_next.pwr_n = 1'b1;
                end
                else if (sleep_instruction)
                begin
                    wdt_clear       = 1'b1;
                    s_next.pwr_n    = 1'b0;
                    s_next.to_n     = 1'b1;
                    s_next.prefetch = 1'b1;
                    if (irq_pending)
                    begin
                        // Sleep completes, then the pending source wakes at once.
                        s_next.resume = 1'b1;
                        s_next.vector = global_interrupt_enable;
                        ev_set[WSW_EV_IRQ_WAKE] = 1'b1;
                    end
                    else
                    begin
                        s_next.state = WSW_SLEEP;
                    end
                end
                else if (wdt_expire)
                begin
                    // Internal reset only; the master-clear pin stays an input.
                    s_next.dev_rst = 1'b1;
                    s_next.to_n    = 1'b0;
                    s_next.option  = WSW_OPTION_RST;
                    ev_set[WSW_EV_WDT_RESET] = 1'b1;
                end
            end
            WSW_SLEEP:
            begin
                if (wdt_expire || irq_pending)
                begin
                    wdt_clear       = 1'b1;
                    s_next.int_wake = !wdt_expire;
                    if (wdt_expire)
                    begin
                        s_next.to_n = 1'b0;
                        ev_set[WSW_EV_WDT_WAKE] = 1'b1;
                    end
                    else
                    begin
                        ev_set[WSW_EV_IRQ_WAKE] = 1'b1;
                    end
                    if (crystal_mode)
                    begin
                        ost_start    = 1'b1;
                        s_next.state = WSW_START;
                    end
                    else
                    begin
                        s_next.state  = WSW_RUN;
                        s_next.resume = 1'b1;
                        s_next.vector = !wdt_expire && global_interrupt_enable;
                    end
                end
            end
            WSW_START:
            begin
                if (ost_done)
                begin
                    s_next.state  = WSW_RUN;
                    s_next.resume = 1'b1;
                    s_next.vector = s_reg.int_wake && global_interrupt_enable;
                end
            end
            default:
            begin
                s_next.state = WSW_RUN;
            end
        endcase

        // Master-clear resets the device from any state, asleep or not.
        if (pin_rst)
        begin
            s_next.state    = WSW_RUN;
            s_next.dev_rst  = 1'b1;
            s_next.option   = WSW_OPTION_RST;
            s_next.resume   = 1'b0;
            s_next.vector   = 1'b0;
            s_next.prefetch = 1'b0;
            wdt_clear       = 1'b1;
        end

        // Data phase of a write takes hwdata.
        if (s_reg.wr_pend)
        begin
            case (s_reg.wr_addr)
                WSW_OPTION_ADDR:
                begin
                    if (!pin_rst && !s_next.dev_rst)
                        s_next.option = hwdata[7:0];
                end
                WSW_IRQ_CLR_ADDR:
                begin
                    ev_clr = hwdata[2:0];
                end
                WSW_IRQ_EN_ADDR:
                begin
                    s_next.irq_en = hwdata[2:0];
                end
                default:
                begin
                    ev_clr = 3'h0;
                end
            endcase
        end

        // Sticky events; a set in the clearing cycle wins.
        s_next.irq_sts = (s_reg.irq_sts & ~ev_clr) | ev_set;

        // Address phase: latch writes, capture read data for the next cycle.
        s_next.wr_pend = addr_phase && hwrite;
        s_next.wr_addr = haddr[15:0];
        if (addr_phase && !hwrite)
        begin
            case (haddr[15:0])
                WSW_CORE_STS_ADDR:
                    s_next.rdata = {27'h0, wdt_enable, osc_driver_en, core_halt, s_reg.pwr_n, s_reg.to_n};
                WSW_IRQ_STS_ADDR:
                    s_next.rdata = {29'h0, s_reg.irq_sts};
                WSW_IRQ_EN_ADDR:
                    s_next.rdata = {29'h0, s_reg.irq_en};
                WSW_OPTION_ADDR:
                    s_next.rdata = {24'h0, s_reg.option};
                WSW_CONFIG_ADDR:
                    s_next.rdata = {24'h0, config_word};
                default:
                    s_next.rdata = 32'h0;
            endcase
        end
    end

    // State register; power-up sets both status flags.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_reg          <= '0;
            s_reg.state    <= WSW_RUN;
            s_reg.option   <= WSW_OPTION_RST;
            s_reg.to_n     <= 1'b1;
            s_reg.pwr_n    <= 1'b1;
            s_reg.irq_sts  <= WSW_IRQ_RST;
            s_reg.irq_en   <= WSW_IRQ_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs to the core, the pins and the bus.
    assign device_reset            = s_reg.dev_rst;
    assign timeout_status_flag_n   = s_reg.to_n;
    assign powerdown_status_flag_n = s_reg.pwr_n;
    assign osc_driver_en           = s_reg.state != WSW_SLEEP;
    assign io_hold                 = s_reg.state != WSW_RUN;
    assign core_halt               = s_reg.state != WSW_RUN;
    assign prefetch_next           = s_reg.prefetch;
    assign resume_exec             = s_reg.resume;
    assign vector_after_next       = s_reg.vector;
    assign irq                     = |(s_reg.irq_sts & s_reg.irq_en);
    assign hrdata                  = s_reg.rdata;
    assign hreadyout               = 1'b1;
    assign hresp                   = 1'b0;
endmodule : wsw_top
`default_nettype wire

/* test/wsw_core_model.sv */
// Purpose: Model of the core, interrupt and reset side of the block.
// Assumes: Strobes are one-cycle pulses launched just after a rising edge.
// Notes:   A halted core issues no strobe.
`default_nettype none
module wsw_core_model (
    // Clock and core state.
    input  wire logic clk_sys,
    input  wire logic core_halt,
    // Strobes, interrupt levels, pin and fuse.
    output logic       clear_watchdog_instruction,
    output logic       sleep_instruction,
    output logic [7:0] irq_flags,
    output logic [7:0] irq_enables,
    output logic       global_interrupt_enable,
    output logic       master_clear_pin_n,
    output logic [7:0] config_word
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet levels at time zero, watchdog fuse set, RC mode.
    initial
    begin
        {clear_watchdog_instruction, sleep_instruction, irq_flags, irq_enables, global_interrupt_enable} = '0;
        master_clear_pin_n = 1'b1;
        config_word = 8'h0d;
    end

    // Executes one clear or sleep instruction.
    task automatic execute(input logic slp);
        @(posedge clk_sys);
        if (core_halt === 1'b0)
        begin
            clear_watchdog_instruction <= ~slp;
            sleep_instruction <= slp;
        end
        @(posedge clk_sys);
        clear_watchdog_instruction <= 1'b0;
        sleep_instruction <= 1'b0;
    endtask

    // Sets interrupt, pin and fuse levels.
    task automatic levels(input logic [7:0] f, e, input logic g, m, input logic [7:0] c);
        @(posedge clk_sys);
        irq_flags <= f;
        irq_enables <= e;
        global_interrupt_enable <= g;
        master_clear_pin_n <= m;
        config_word <= c;
    endtask
endmodule // wsw_core_model
`default_nettype wire

/* test/wsw_top_props.sv */
// Purpose: Concurrent checks on the ports of the block.
// Assumes: One clock domain; rst is asynchronous and active high.
// Notes:   Master-clear resets are told apart by the pin's last two samples.
`default_nettype none
module wsw_top_props (
    // Clock and reset.
    input wire logic       clk_sys,
    input wire logic       rst,
    // Core, pin and fuse inputs.
    input wire logic       clear_watchdog_instruction,
    input wire logic       sleep_instruction,
    input wire logic       global_interrupt_enable,
    input wire logic       master_clear_pin_n,
    input wire logic [7:0] config_word,
    // Core and reset control outputs.
    input wire logic       device_reset,
    input wire logic       timeout_status_flag_n,
    input wire logic       powerdown_status_flag_n,
    input wire logic       osc_driver_en,
    input wire logic       io_hold,
    input wire logic       core_halt,
    input wire logic       prefetch_next,
    input wire logic       resume_exec,
    input wire logic       vector_after_next
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Flag, reset and sleep relations.
    chk_clear_flags: assert property (clear_watchdog_instruction && !core_halt && master_clear_pin_n
        |=> timeout_status_flag_n && powerdown_status_flag_n) else $error("clear left a flag low");
    chk_sleep_entry: assert property (sleep_instruction && !clear_watchdog_instruction && !core_halt
        && master_clear_pin_n |=> !powerdown_status_flag_n && prefetch_next) else $error("sleep entry wrong");
    chk_wdt_reset: assert property (device_reset && $past(master_clear_pin_n) && $past(master_clear_pin_n, 2)
        |-> !timeout_status_flag_n) else $error("reset without time-out flag");
    chk_reset_pulse: assert property (device_reset && master_clear_pin_n && $past(master_clear_pin_n)
        && $past(master_clear_pin_n, 2) |=> !device_reset) else $error("reset longer than a cycle");
    chk_asleep_no_reset: assert property (core_halt && $past(core_halt) && $past(master_clear_pin_n)
        && $past(master_clear_pin_n, 2) |-> !device_reset) else $error("reset while asleep");
    chk_asleep_state: assert property (!osc_driver_en
        |-> io_hold && core_halt && !powerdown_status_flag_n) else $error("sleep state outputs wrong");
    chk_vector_wake: assert property (vector_after_next
        |-> resume_exec && $past(global_interrupt_enable)) else $error("vector without interrupt wake");
    chk_sleep_lands: assert property (prefetch_next
        |-> ##[0:1] (!osc_driver_en || resume_exec)) else $error("sleep neither stopped nor woke");
    chk_fuse_off: assert property (!$past(config_word[3]) && !$past(config_word[3], 2)
        && $past(master_clear_pin_n) && $past(master_clear_pin_n, 2) |-> !device_reset)
        else $error("reset with fuse off");
endmodule // wsw_top_props

bind wsw_top wsw_top_props u_props (.clk_sys, .rst, .clear_watchdog_instruction, .sleep_instruction,
    .global_interrupt_enable, .master_clear_pin_n, .config_word, .device_reset, .timeout_status_flag_n,
    .powerdown_status_flag_n, .osc_driver_en, .io_hold, .core_halt, .prefetch_next, .resume_exec,
    .vector_after_next);
`default_nettype wire

/* test/wsw_top_test.sv */
// Purpose: Self-checking bench of the watchdog, sleep and wake-up block.
// Assumes: Watchdog base period shortened to 20 cycles; clock 100 MHz.
// Notes:   Register reads first, then time-out rows, sleep, wake, master clear and fuse cases.
`default_nettype none
module wsw_top_test;
    import wsw_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int BASE = 20;
    typedef struct packed { logic [7:0] opt, mul; } wsw_row_s;

    // Bus master, clock and reset.
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    // Core side levels and block outputs.
    logic        clear_watchdog_instruction, sleep_instruction, global_interrupt_enable, master_clear_pin_n;
    logic [7:0]  irq_flags, irq_enables, config_word;
    logic        device_reset, timeout_status_flag_n, powerdown_status_flag_n, osc_driver_en, io_hold;
    logic        core_halt, prefetch_next, resume_exec, vector_after_next, irq;
    int          bad_count = 0, checks = 0, resets = 0, n, base;
    wsw_row_s    rows [4] = '{'{8'h00, 8'd1}, '{8'h08, 8'd1}, '{8'h09, 8'd2}, '{8'h0b, 8'd8}};

    wsw_top #(.WDT_BASE_CYCLES(BASE)) DUT (.hready(hreadyout), .*);
    wsw_core_model core (.*);

    // Clock and a count of device resets.
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (device_reset === 1'b1)
            resets <= resets + 1;

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits, bounded, for ready, resume or reset; n counts edges.
    function automatic logic pick(input int s);
        return s == 0 ? hreadyout : (s == 1 ? resume_exec : device_reset);
    endfunction
    task automatic await(input int s, input int lim);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pick(s) !== 1'b1 && n < lim);
        if (pick(s) !== 1'b1)
        begin
            bad_count++;
            test_done();
        end
    endtask

    // One word transfer; read data lands in rd.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {16'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        await(0, 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        await(0, 50);
        rd = hrdata;
    endtask

    // Clears, sets the option register, then clears again.
    task automatic arm(input logic [7:0] opt);
        core.execute(1'b0);
        bus(1'b1, WSW_OPTION_ADDR, {24'h0, opt});
        core.execute(1'b0);
    endtask

    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask

    initial
    begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, read-only and unmapped places.
        bus(1'b0, WSW_OPTION_ADDR, 0);
        chk(rd, 32'hff);
        bus(1'b0, WSW_CORE_STS_ADDR, 0);
        chk(rd, 32'h1b);
        bus(1'b1, WSW_CONFIG_ADDR, 0);
        bus(1'b0, WSW_CONFIG_ADDR, 0);
        chk(rd, 32'h0d);
        bus(1'b0, 16'h0100, 0);
        chk(rd, 0);
        chk(hresp, 0);
        // Time-out length per prescaler setting, reset and flag.
        foreach (rows[i])
        begin
            arm(rows[i].opt);
            await(2, 400);
            chk(n >= BASE * rows[i].mul - 1 && n <= BASE * rows[i].mul + 3, 1);
            chk(timeout_status_flag_n, 0);
            bus(1'b0, WSW_OPTION_ADDR, 0);
            chk(rd, 32'hff);
        end
        // Clears closer than the period keep the watchdog quiet.
        arm(8'h00);
        base = resets;
        repeat (6)
        begin
            repeat (12) @(posedge clk_sys);
            core.execute(1'b0);
        end
        chk(resets - base, 0);
        // Watchdog wake from sleep in RC mode; interrupt masked, enabled, cleared.
        bus(1'b1, WSW_IRQ_CLR_ADDR, 32'h7);
        bus(1'b1, WSW_IRQ_EN_ADDR, 32'h0);
        core.execute(1'b1);
        settle();
        chk({osc_driver_en, io_hold, powerdown_status_flag_n, timeout_status_flag_n}, 4'b0101);
        await(1, 100);
        chk({timeout_status_flag_n, 16'(resets - base)}, 0);
        bus(1'b0, WSW_IRQ_STS_ADDR, 0);
        chk(rd, 32'h2);
        chk(irq, 0);
        bus(1'b1, WSW_IRQ_EN_ADDR, 32'h2);
        settle();
        chk(irq, 1);
        bus(1'b1, WSW_IRQ_CLR_ADDR, 32'h2);
        settle();
        chk(irq, 0);
        // Interrupt wake with and without the global enable.
        arm(8'hff);
        for (int g = 1; g >= 0; g--)
        begin
            core.levels(8'h00, 8'h04, g[0], 1'b1, 8'h0d);
            core.execute(1'b1);
            repeat (5) @(posedge clk_sys);
            core.levels(8'h04, 8'h04, g[0], 1'b1, 8'h0d);
            await(1, 20);
            chk({vector_after_next, timeout_status_flag_n}, {g[0], 1'b1});
        end
        // Pending enabled interrupt: sleep completes and wakes at once.
        core.execute(1'b1);
        await(1, 4);
        chk(osc_driver_en, 1);
        // A flag without its enable does not wake; master clear does.
        core.levels(8'h04, 8'h00, 1'b1, 1'b1, 8'h0d);
        core.execute(1'b1);
        repeat (30) @(posedge clk_sys);
        chk(osc_driver_en, 0);
        core.levels(8'h04, 8'h00, 1'b1, 1'b0, 8'h0d);
        await(2, 5);
        core.levels(8'h00, 8'h04, 1'b0, 1'b1, 8'h0a);
        settle();
        chk(osc_driver_en, 1);
        // Crystal mode waits for the start-up timer.
        core.execute(1'b1);
        core.levels(8'h04, 8'h04, 1'b0, 1'b1, 8'h0a);
        await(1, 1200);
        chk(n >= WSW_OST_TOSC && n <= WSW_OST_TOSC + 4, 1);
        // Fuse off: no time-out even with the shortest period.
        core.levels(8'h00, 8'h00, 1'b0, 1'b1, 8'h05);
        arm(8'h00);
        base = resets;
        repeat (100) @(posedge clk_sys);
        chk(resets - base, 0);
        bus(1'b0, WSW_CORE_STS_ADDR, 0);
        chk(rd[4], 0);
        test_done();
    end
endmodule // wsw_top_test
`default_nettype wire
